// file: src/prot_check_pkg.sv
// How it works
// - Real mode: protected-only opcode raises undefined opcode vector 6.
// - Real mode: word operand at offset ffff raises overrun vector 13.
// - Initialization opcodes run in real mode without the undefined opcode fault.
// - Real mode flag loads force io level field and nested bit to zero.
// - Real mode: coprocessor operand past segment limit raises vector 9.
// - Exchange-type instructions assert the bus lock with or without prefix.
// - Multi-transfer lock may drop between operand transfers.
// - Protected: limit or rights fault gives 13; stack limit gives 12.
// - Segment loads check privilege levels; not present gives vector 11.
// - Stack segment load of absent segment gives 12 instead of 11.
// - Descriptor table accesses for segment loads assert the bus lock.
// - Far transfers to another code segment: privilege fault gives 13.
// - Privileged opcode at nonzero level, or level above io level: 13.
// - Flag load keeps interrupt bit if level above io; io field needs 0.
// - Selector check privilege failure: no fault, no result, zero cleared.
// - Coprocessor start fault gives 13 or 12; transfer overrun gives 9.
// - Far transfer target beyond code segment limit gives 13.
package prot_check_pkg;

    localparam logic [7:0] VEC_UNDEF = 8'h06;
    localparam logic [7:0] VEC_COP_OVR = 8'h09;
    localparam logic [7:0] VEC_NOT_PRESENT = 8'h0b;
    localparam logic [7:0] VEC_STACK = 8'h0c;
    localparam logic [7:0] VEC_GP = 8'h0d;
    localparam logic [15:0] OFFSET_LAST = 16'hffff;

    localparam int FLAG_IF = 9;
    localparam int FLAG_IO_PRIVILEGE_LEVEL_LO = 12;
    localparam int FLAG_NT = 14;

    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_MASK = 12'h008;
    localparam logic [11:0] ADDR_LAST_VEC = 12'h00c;

    localparam int EV_UNDEF = 0;
    localparam int EV_COP = 1;
    localparam int EV_NP = 2;
    localparam int EV_STACK = 3;
    localparam int EV_GP = 4;
    localparam int EV_SEL = 5;
    localparam int EV_W = 6;

    localparam logic CTRL_RESET = 1'b0;
    localparam logic [EV_W-1:0] MASK_RESET = 6'h00;

    typedef struct packed {
        logic valid;
        logic prot_only;
        logic init_op;
        logic mem_op;
        logic word_op;
        logic stack_seg;
        logic rights_ok;
        logic [15:0] offset;
        logic [15:0] last_offset;
        logic [15:0] seg_limit;
        logic seg_load;
        logic dest_ss;
        logic present;
        logic [1:0] current_privilege_level;
        logic [1:0] requested_privilege_level;
        logic [1:0] descriptor_privilege_level;
        logic far_xfer;
        logic [15:0] target_offset;
        logic [15:0] code_limit;
        logic privileged;
        logic io_sensitive;
        logic flag_load;
        logic [15:0] old_flags;
        logic [15:0] new_flags;
        logic sel_check;
        logic cop_op;
        logic cop_xfer;
        logic xchg;
        logic lock_prefix;
        logic desc_access;
        logic multi_xfer;
        logic xfer_active;
    } check_req_type;

    typedef struct packed {
        logic done;
        logic fault;
        logic commit;
        logic zero_flag_clear;
        logic [7:0] vector;
        logic [15:0] flags;
    } check_resp_type;

endpackage : prot_check_pkg

// file: src/protection_exception_checker.sv
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module protection_exception_checker
    import prot_check_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire check_req_type req,
    output check_resp_type resp,
    output logic bus_lock,
    output logic irq
);

    logic prot_mode_reg;
    logic [EV_W-1:0] status_reg;
    logic [EV_W-1:0] status_next;
    logic [EV_W-1:0] mask_reg;
    logic [7:0] last_vec_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    check_resp_type resp_reg;
    check_resp_type resp_next;
    logic [EV_W-1:0] events;
    logic bus_lock_reg;

    logic real_mode;
    logic [1:0] eff_level;
    logic [1:0] io_level;
    logic lim_viol;
    logic seg_priv_bad;
    logic far_priv_bad;
    logic apb_wr;
    logic apb_rd;
    logic addr_ok;

    assign real_mode = !prot_mode_reg;
    assign eff_level = (req.current_privilege_level > req.requested_privilege_level) ? req.current_privilege_level : req.requested_privilege_level;
    assign io_level = req.old_flags[FLAG_IO_PRIVILEGE_LEVEL_LO +: 2];
    assign lim_viol = (req.offset > req.seg_limit)
                    || (req.last_offset > req.seg_limit);
    // Stack loads need exact level match; data loads the usual max rule
    assign seg_priv_bad = req.dest_ss
        ? ((req.requested_privilege_level != req.current_privilege_level) || (req.descriptor_privilege_level != req.current_privilege_level))
        : (eff_level > req.descriptor_privilege_level);
    assign far_priv_bad = eff_level > req.descriptor_privilege_level;

    // Checks in fixed priority so one vector leaves per instruction
    always_comb begin
        resp_next = '0;
        resp_next.done = req.valid;
        resp_next.flags = req.old_flags;
        if (real_mode) begin
            if (req.prot_only && !req.init_op) begin
                resp_next.fault = 1'b1;
                resp_next.vector = VEC_UNDEF;
            end else if (req.mem_op && req.word_op
                         && req.offset == OFFSET_LAST) begin
                resp_next.fault = 1'b1;
                resp_next.vector = VEC_GP;
            end else if (req.cop_op
                         && req.last_offset > req.seg_limit) begin
                resp_next.fault = 1'b1;
                resp_next.vector = VEC_COP_OVR;
            end
        end else begin
            if (req.privileged && req.current_privilege_level != 2'd0) begin
                resp_next.fault = 1'b1;
                resp_next.vector = VEC_GP;
            end else if (req.io_sensitive && req.current_privilege_level > io_level) begin
                resp_next.fault = 1'b1;
                resp_next.vector = VEC_GP;
            end else if (req.seg_load && seg_priv_bad) begin
                if (req.sel_check) begin
                    resp_next.zero_flag_clear = 1'b1;
                end else begin
                    resp_next.fault = 1'b1;
                    resp_next.vector = VEC_GP;
                end
            end else if (req.seg_load && !req.present) begin
                resp_next.fault = 1'b1;
                resp_next.vector = req.dest_ss ? VEC_STACK
                                               : VEC_NOT_PRESENT;
            end else if (req.far_xfer && (far_priv_bad
                         || req.target_offset > req.code_limit)) begin
                resp_next.fault = 1'b1;
                resp_next.vector = VEC_GP;
            end else if (req.cop_op && req.cop_xfer && lim_viol) begin
                resp_next.fault = 1'b1;
                resp_next.vector = VEC_COP_OVR;
            end else if ((req.mem_op || req.cop_op)
                         && (lim_viol || !req.rights_ok)) begin
                resp_next.fault = 1'b1;
                resp_next.vector = (req.stack_seg && lim_viol)
                                 ? VEC_STACK : VEC_GP;
            end
        end
        if (req.flag_load) begin
            resp_next.flags = req.new_flags;
            if (real_mode) begin
                resp_next.flags[FLAG_IO_PRIVILEGE_LEVEL_LO +: 2] = 2'b00;
                resp_next.flags[FLAG_NT] = 1'b0;
            end else begin
                if (req.current_privilege_level > io_level) begin
                    resp_next.flags[FLAG_IF] = req.old_flags[FLAG_IF];
                end
                if (req.current_privilege_level != 2'd0) begin
                    resp_next.flags[FLAG_IO_PRIVILEGE_LEVEL_LO +: 2] = io_level;
                end
            end
        end
        // Faulted or failed selector checks leave no result behind
        resp_next.commit = req.valid && !resp_next.fault
                         && !resp_next.zero_flag_clear;
        if (!req.valid) begin
            resp_next = '0;
            resp_next.flags = req.old_flags;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            resp_reg <= '0;
        end else begin
            resp_reg <= resp_next;
        end
    end
    assign resp = resp_reg;

    // Lock is per transfer, so multi-transfer sequences may show gaps
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_lock_reg <= 1'b0;
        end else begin
            bus_lock_reg <= req.valid && (req.xchg || req.desc_access
                || (req.lock_prefix
                    && (!req.multi_xfer || req.xfer_active)));
        end
    end
    assign bus_lock = bus_lock_reg;

    always_comb begin
        events = '0;
        events[EV_UNDEF] = resp_reg.fault && resp_reg.vector == VEC_UNDEF;
        events[EV_COP] = resp_reg.fault && resp_reg.vector == VEC_COP_OVR;
        events[EV_NP] = resp_reg.fault && resp_reg.vector == VEC_NOT_PRESENT;
        events[EV_STACK] = resp_reg.fault && resp_reg.vector == VEC_STACK;
        events[EV_GP] = resp_reg.fault && resp_reg.vector == VEC_GP;
        events[EV_SEL] = resp_reg.zero_flag_clear;
    end

    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && !penable && !pwrite;
    assign addr_ok = paddr == ADDR_CTRL || paddr == ADDR_STATUS
                  || paddr == ADDR_MASK || paddr == ADDR_LAST_VEC;

    // Set wins over a write-one clear in the same cycle
    always_comb begin
        status_next = status_reg;
        if (apb_wr && paddr == ADDR_STATUS) begin
            status_next = status_next & ~pwdata[EV_W-1:0];
        end
        status_next = status_next | events;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= '0;
            last_vec_reg <= 8'h00;
        end else begin
            status_reg <= status_next;
            if (resp_reg.fault) begin
                last_vec_reg <= resp_reg.vector;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prot_mode_reg <= CTRL_RESET;
            mask_reg <= MASK_RESET;
        end else if (apb_wr) begin
            if (paddr == ADDR_CTRL) begin
                prot_mode_reg <= pwdata[0];
            end
            if (paddr == ADDR_MASK) begin
                mask_reg <= pwdata[EV_W-1:0];
            end
        end
    end

    // Read data is captured in setup so the access phase is one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else begin
            if (apb_rd) begin
                unique case (paddr)
                    ADDR_CTRL: prdata_reg <= {31'h0, prot_mode_reg};
                    ADDR_STATUS: prdata_reg <= {26'h0, status_reg};
                    ADDR_MASK: prdata_reg <= {26'h0, mask_reg};
                    ADDR_LAST_VEC: prdata_reg <= {24'h0, last_vec_reg};
                    default: prdata_reg <= 32'h0000_0000;
                endcase
            end
            if (psel && !penable) begin
                pslverr_reg <= !addr_ok;
            end
        end
    end

    assign prdata = prdata_reg;
    assign pready = 1'b1;
    assign pslverr = pslverr_reg && psel && penable;
    assign irq = |(status_reg & mask_reg);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_real_prot_op;
        req.valid && real_mode && req.prot_only && !req.init_op;
    endsequence
    sequence s_undef_out;
        resp.fault && resp.vector == VEC_UNDEF;
    endsequence

    chk_undef_opcode: assert property (s_real_prot_op |=> s_undef_out)
        else $error("real mode protected opcode missed vector 6");
    chk_init_allowed: assert property (req.valid && real_mode
        && req.init_op |=> !resp.fault || resp.vector != VEC_UNDEF)
        else $error("init opcode faulted as undefined");
    chk_word_overrun: assert property (req.valid && real_mode
        && !req.prot_only && req.mem_op && req.word_op
        && req.offset == 16'hffff |=> resp.fault && resp.vector == VEC_GP)
        else $error("word at last offset missed vector 13");
    chk_real_flags: assert property (req.valid && real_mode
        && req.flag_load |=> resp.flags[13:12] == 2'b00 && !resp.flags[14])
        else $error("real mode flag load kept io level or nested bit");
    chk_xchg_lock: assert property (req.valid && req.xchg
        |=> bus_lock)
        else $error("exchange did not lock bus");
    chk_desc_lock: assert property (req.valid && req.desc_access
        |=> bus_lock)
        else $error("descriptor access did not lock bus");
    chk_ss_absent: assert property (req.valid && !real_mode
        && req.seg_load && req.dest_ss && !req.present && !seg_priv_bad
        && !req.privileged && !req.io_sensitive
        |=> resp.fault && resp.vector == VEC_STACK)
        else $error("absent stack segment missed vector 12");
    chk_priv_op: assert property (req.valid && !real_mode
        && req.privileged && req.current_privilege_level != 2'd0
        |=> resp.fault && resp.vector == VEC_GP && !resp.commit)
        else $error("privileged opcode at nonzero level not trapped");
    chk_if_kept: assert property (req.valid && !real_mode
        && req.flag_load && req.current_privilege_level > io_level
        |=> resp.flags[9] == $past(req.old_flags[9]))
        else $error("interrupt bit changed above io level");
    chk_sel_nofault: assert property (resp.zero_flag_clear
        |-> !resp.fault && !resp.commit)
        else $error("selector check faulted or committed");
    chk_one_answer: assert property (resp.fault |-> !resp.commit
        ##1 last_vec_reg == $past(resp.vector))
        else $error("faulted result committed or vector not passed on");
    chk_sticky_irq: assert property (resp.fault && resp.vector == VEC_GP
        && mask_reg[EV_GP] && !(apb_wr && paddr == ADDR_MASK) |=> irq)
        else $error("masked-in event did not raise interrupt");

    // Each check strips the causes that outrank it from its antecedent
    sequence s_prot_plain;
        req.valid && !real_mode && !req.privileged && !req.io_sensitive
            && !req.seg_load && !req.far_xfer;
    endsequence
    sequence s_prot_seg;
        req.valid && !real_mode && !req.privileged && !req.io_sensitive
            && req.seg_load && !req.dest_ss;
    endsequence
    sequence s_prot_far;
        req.valid && !real_mode && !req.privileged && !req.io_sensitive
            && !req.seg_load && req.far_xfer;
    endsequence

    sequence s_gp_out;
        resp.fault && resp.vector == VEC_GP && !resp.commit;
    endsequence
    sequence s_stack_out;
        resp.fault && resp.vector == VEC_STACK && !resp.commit;
    endsequence
    sequence s_cop_out;
        resp.fault && resp.vector == VEC_COP_OVR && !resp.commit;
    endsequence

    chk_cop_real: assert property (req.valid && real_mode
        && !req.prot_only && !(req.mem_op && req.word_op)
        && req.cop_op && req.last_offset > req.seg_limit |=> s_cop_out)
        else $error("real mode coprocessor overrun missed vector 9");
    chk_io_op: assert property (req.valid && !real_mode
        && !req.privileged
        && req.io_sensitive && req.current_privilege_level > req.old_flags[13:12] |=> s_gp_out)
        else $error("io sensitive opcode above io level not trapped");

    chk_prefix_lock: assert property (req.valid && req.lock_prefix
        && !req.multi_xfer |=> bus_lock)
        else $error("prefixed single transfer did not lock bus");
    // Gaps are allowed, and this block takes them between operands
    chk_multi_gap: assert property (req.valid && req.lock_prefix
        && req.multi_xfer && !req.xfer_active && !req.xchg
        && !req.desc_access |=> !bus_lock)
        else $error("lock held outside a multi-transfer operand");

    chk_limit_gp: assert property (s_prot_plain ##0 (req.mem_op
        && !req.cop_op && !req.stack_seg && (req.offset > req.seg_limit
        || req.last_offset > req.seg_limit)) |=> s_gp_out)
        else $error("segment limit fault missed vector 13");
    chk_stack_limit: assert property (s_prot_plain ##0 (req.mem_op
        && !req.cop_op && req.stack_seg && (req.offset > req.seg_limit
        || req.last_offset > req.seg_limit)) |=> s_stack_out)
        else $error("stack limit fault missed vector 12");
    chk_rights_gp: assert property (s_prot_plain ##0 (req.mem_op
        && !req.cop_op && !req.rights_ok && req.offset <= req.seg_limit
        && req.last_offset <= req.seg_limit) |=> s_gp_out)
        else $error("access rights fault missed vector 13");

    chk_seg_priv: assert property (s_prot_seg ##0 (!req.sel_check
        && (req.current_privilege_level > req.descriptor_privilege_level || req.requested_privilege_level > req.descriptor_privilege_level)) |=> s_gp_out)
        else $error("segment load privilege fault missed vector 13");
    chk_not_present: assert property (s_prot_seg ##0 (!req.present
        && req.current_privilege_level <= req.descriptor_privilege_level && req.requested_privilege_level <= req.descriptor_privilege_level)
        |=> resp.fault && resp.vector == VEC_NOT_PRESENT)
        else $error("absent segment missed vector 11");
    chk_sel_zero: assert property (s_prot_seg ##0 (req.sel_check
        && req.requested_privilege_level > req.descriptor_privilege_level)
        |=> resp.zero_flag_clear && !resp.fault && !resp.commit)
        else $error("selector check privilege fault not reported in flag");

    chk_far_priv: assert property (s_prot_far ##0 (req.current_privilege_level > req.descriptor_privilege_level
        || req.requested_privilege_level > req.descriptor_privilege_level) |=> s_gp_out)
        else $error("far transfer privilege fault missed vector 13");
    chk_far_limit: assert property (s_prot_far ##0 (req.target_offset
        > req.code_limit) |=> s_gp_out)
        else $error("far transfer target beyond limit missed vector 13");

    chk_cop_start: assert property (s_prot_plain ##0 (req.cop_op
        && !req.cop_xfer && !req.stack_seg && req.offset > req.seg_limit)
        |=> s_gp_out)
        else $error("coprocessor operand start fault missed vector 13");
    chk_cop_stack: assert property (s_prot_plain ##0 (req.cop_op
        && !req.cop_xfer && req.stack_seg && req.offset > req.seg_limit)
        |=> s_stack_out)
        else $error("coprocessor stack start fault missed vector 12");
    chk_cop_xfer: assert property (s_prot_plain ##0 (req.cop_op
        && req.cop_xfer && req.last_offset > req.seg_limit) |=> s_cop_out)
        else $error("coprocessor transfer overrun missed vector 9");

    chk_io_field: assert property (req.valid && !real_mode
        && req.flag_load && req.current_privilege_level != 2'd0
        |=> resp.flags[13:12] == $past(req.old_flags[13:12]))
        else $error("io level field changed at nonzero level");
    // A clear in the same cycle must not hide the event
    chk_set_wins: assert property (resp.fault
        && resp.vector == VEC_GP |=> status_reg[EV_GP])
        else $error("fault event lost from status");

endmodule : protection_exception_checker
`default_nettype wire

// file: sim/instruction_source.sv
`timescale 1ns/1ns
`default_nettype none
module instruction_source
    import prot_check_pkg::*;
(
    input wire logic pclk,
    input wire logic go,
    input wire check_req_type cmd,
    output check_req_type req
);
    // Idle fields are scrambled so a stale operand can never pass for valid
    check_req_type last_reg = '0;
    always @(posedge pclk) begin
        if (go) begin
            last_reg <= cmd;
        end
    end
    always_comb begin
        req = go ? cmd : check_req_type'(~last_reg);
        req.valid = go;
    end
endmodule : instruction_source
`default_nettype wire

// file: sim/protection_exception_checker_test.sv
`timescale 1ns/1ns
`default_nettype none
module protection_exception_checker_test
    import prot_check_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, bus_lock, irq, go = 1'b0;
    check_req_type cmd = '0;
    check_req_type req;
    check_resp_type resp;
    int fails = 0;
    int total_checks = 0;

    always #50 pclk = ~pclk;

    instruction_source i_instruction_source(.pclk(pclk), .go(go),
        .cmd(cmd), .req(req));
    protection_exception_checker i_protection_exception_checker(
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .req(req), .resp(resp),
        .bus_lock(bus_lock), .irq(irq));

    task automatic chk(input string nm, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d, output logic [31:0] q, output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        logic er;
        apb(1'b0, a, 32'h0, q, er);
        chk("prdata", e, q);
        chk("pslverr", 1'b0, er);
    endtask : rd

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic er;
        apb(1'b1, a, d, q, er);
    endtask : wr

    function automatic check_req_type base();
        check_req_type r;
        r = '0;
        r.valid = 1'b1;
        r.rights_ok = 1'b1;
        r.present = 1'b1;
        r.seg_limit = 16'hffff;
        r.code_limit = 16'hffff;
        return r;
    endfunction : base

    task automatic run(input check_req_type r);
        @(posedge pclk);
        cmd <= r;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        @(negedge pclk);
    endtask : run

    // Vector 0 stands for no fault expected
    task automatic vec(input check_req_type r, input logic [7:0] v);
        run(r);
        chk("done", 1'b1, resp.done);
        chk("fault", v != 8'h00, resp.fault);
        chk("commit", v == 8'h00, resp.commit);
        if (v != 8'h00) begin
            chk("vector", v, resp.vector);
        end
    endtask : vec

    task automatic lck(input logic [4:0] f, input logic e);
        check_req_type r;
        r = base();
        {r.xchg, r.lock_prefix, r.multi_xfer, r.xfer_active,
            r.desc_access} = f;
        run(r);
        chk("bus_lock", e, bus_lock);
    endtask : lck

    task automatic test_regs();
        logic [31:0] q;
        logic er;
        rd(ADDR_CTRL, 32'h0);
        rd(ADDR_MASK, 32'h0);
        rd(ADDR_STATUS, 32'h0);
        apb(1'b0, 12'h010, 32'h0, q, er);
        chk("unmapped err", 1'b1, er);
        chk("unmapped data", 32'h0, q);
        $display("test_regs done");
    endtask : test_regs

    task automatic test_real();
        check_req_type r;
        r = base();
        r.prot_only = 1'b1;
        vec(r, VEC_UNDEF);
        r.init_op = 1'b1;
        vec(r, 8'h00);
        r = base();
        r.mem_op = 1'b1;
        r.offset = OFFSET_LAST;
        vec(r, 8'h00);
        r.word_op = 1'b1;
        vec(r, VEC_GP);
        r = base();
        r.cop_op = 1'b1;
        r.seg_limit = 16'h000f;
        r.last_offset = 16'h0010;
        vec(r, VEC_COP_OVR);
        r = base();
        r.flag_load = 1'b1;
        r.new_flags = 16'hffff;
        vec(r, 8'h00);
        chk("flags", 16'h8fff, resp.flags);
        $display("test_real done");
    endtask : test_real

    task automatic test_lock();
        lck(5'b10000, 1'b1);
        lck(5'b01000, 1'b1);
        lck(5'b01100, 1'b0);
        lck(5'b01110, 1'b1);
        lck(5'b00001, 1'b1);
        lck(5'b00000, 1'b0);
        $display("test_lock done");
    endtask : test_lock

    task automatic test_prot();
        check_req_type r;
        wr(ADDR_CTRL, 32'h1);
        rd(ADDR_CTRL, 32'h1);
        r = base();
        r.privileged = 1'b1;
        vec(r, 8'h00);
        r.current_privilege_level = 2'd1;
        r.mem_op = 1'b1;
        r.offset = 16'h0200;
        r.seg_limit = 16'h00ff;
        vec(r, VEC_GP);
        r = base();
        r.io_sensitive = 1'b1;
        r.current_privilege_level = 2'd3;
        vec(r, VEC_GP);
        r.old_flags = 16'h3000;
        vec(r, 8'h00);
        r = base();
        r.mem_op = 1'b1;
        r.seg_limit = 16'h00ff;
        r.last_offset = 16'h0100;
        vec(r, VEC_GP);
        r.stack_seg = 1'b1;
        vec(r, VEC_STACK);
        r = base();
        r.mem_op = 1'b1;
        r.rights_ok = 1'b0;
        vec(r, VEC_GP);
        r = base();
        r.seg_load = 1'b1;
        r.present = 1'b0;
        vec(r, VEC_NOT_PRESENT);
        r.dest_ss = 1'b1;
        vec(r, VEC_STACK);
        r = base();
        r.seg_load = 1'b1;
        r.requested_privilege_level = 2'd3;
        vec(r, VEC_GP);
        r.sel_check = 1'b1;
        run(r);
        chk("sel fault", 1'b0, resp.fault);
        chk("sel commit", 1'b0, resp.commit);
        chk("sel zero_flag", 1'b1, resp.zero_flag_clear);
        r = base();
        r.far_xfer = 1'b1;
        r.requested_privilege_level = 2'd2;
        r.descriptor_privilege_level = 2'd1;
        vec(r, VEC_GP);
        r.descriptor_privilege_level = 2'd2;
        vec(r, 8'h00);
        r.code_limit = 16'h0fff;
        r.target_offset = 16'h1000;
        vec(r, VEC_GP);
        r = base();
        r.cop_op = 1'b1;
        r.seg_limit = 16'h00ff;
        r.offset = 16'h0100;
        vec(r, VEC_GP);
        r.stack_seg = 1'b1;
        vec(r, VEC_STACK);
        r = base();
        r.cop_op = 1'b1;
        r.cop_xfer = 1'b1;
        r.seg_limit = 16'h00ff;
        r.last_offset = 16'h0101;
        vec(r, VEC_COP_OVR);
        r = base();
        r.flag_load = 1'b1;
        r.current_privilege_level = 2'd3;
        r.new_flags = 16'hffff;
        vec(r, 8'h00);
        chk("flags", 16'hcdff, resp.flags);
        $display("test_prot done");
    endtask : test_prot

    task automatic test_irq();
        check_req_type r;
        chk("irq idle", 1'b0, irq);
        rd(ADDR_STATUS, 32'h3f);
        rd(ADDR_LAST_VEC, {24'h0, VEC_COP_OVR});
        wr(ADDR_MASK, 32'h1 << EV_GP);
        @(negedge pclk);
        chk("irq set", 1'b1, irq);
        wr(ADDR_STATUS, 32'h1 << EV_GP);
        @(negedge pclk);
        chk("irq clear", 1'b0, irq);
        rd(ADDR_STATUS, 32'h2f);
        r = base();
        r.privileged = 1'b1;
        r.current_privilege_level = 2'd1;
        vec(r, VEC_GP);
        @(negedge pclk);
        chk("irq event", 1'b1, irq);
        rd(ADDR_STATUS, 32'h3f);
        $display("test_irq done");
    endtask : test_irq

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        test_regs();
        test_real();
        test_lock();
        test_prot();
        test_irq();
        test_done();
    end

    // Whole sequence needs about a hundred cycles
    initial begin
        repeat (5000) @(posedge pclk);
        fails++;
        test_done();
    end
endmodule : protection_exception_checker_test
`default_nettype wire
